// *** logic/epdsh_pin_if.sv ***
`default_nettype none

interface epdsh_pin_if #(
    parameter int WIDTH = 6
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    modport sync_side (
        input raw,
        output synced
    );

    modport core_side (
        output raw,
        input synced
    );
endinterface

`default_nettype wire

// *** logic/epdsh_pkg.sv ***
`default_nettype none

package epdsh_pkg;

    // pin positions inside the synchroniser bundle
    localparam int PIN_SCLK = 0;
    localparam int PIN_SERIAL_IN_LINE = 1;
    localparam int PIN_SEL_N = 2;
    localparam int PIN_DC = 3;
    localparam int PIN_STRAP = 4;
    localparam int PIN_RST_N = 5;
    localparam int PIN_COUNT = 6;

    // level each synchronised pin shows while in reset: deselected, not in pin reset
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 6'h24;

    // frame shapes
    localparam int BYTE_W = 8;
    localparam int FRAME_W = 9;
    localparam logic [3:0] LAST_BIT_4W = 4'h7;
    localparam logic [3:0] LAST_BIT_3W = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    // strap levels
    localparam logic STRAP_4WIRE = 1'b0;
    localparam logic STRAP_3WIRE = 1'b1;

    // meaning of the data/command level or flag
    localparam logic DC_COMMAND = 1'b0;
    localparam logic DC_DATA = 1'b1;

    // reset values
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [FRAME_W-1:0] SHIFT_RST = 9'h000;

    typedef enum logic [2:0] {
        ST_HELD = 3'b001,
        ST_IDLE = 3'b010,
        ST_SHIFT = 3'b100
    } epdsh_state_t;

endpackage

`default_nettype wire

// *** logic/epdsh_sync.sv ***
`default_nettype none

module epdsh_sync
    import epdsh_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    epdsh_pin_if.sync_side pins
);

    logic [PIN_COUNT-1:0] meta_r;
    logic [PIN_COUNT-1:0] hold_r;

    // two flops per pin; the first is read only by the second
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_bit
        always_ff @(posedge clk_in) begin
            if (srst_in) begin
                meta_r[i] <= PIN_IDLE[i];
                hold_r[i] <= PIN_IDLE[i];
            end else begin
                meta_r[i] <= pins.raw[i];
                hold_r[i] <= meta_r[i];
            end
        end
    end

    assign pins.synced = hold_r;

endmodule

`default_nettype wire

// *** logic/epdsh_write_port.sv ***
`default_nettype none

module epdsh_write_port
    import epdsh_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic sclk_in,
    input wire logic serial_in_line_in,
    input wire logic port_select_n_in,
    input wire logic dc_select_in,
    input wire logic iface_format_strap_in,
    input wire logic reset_in_n_in,
    input wire logic waveform_active_in,
    input wire logic otp_program_in,
    input wire logic sensor_xfer_in,
    output logic [BYTE_W-1:0] byte_out,
    output logic ram_write_out,
    output logic cmd_write_out,
    output logic busy_out,
    output logic format_3wire_out,
    output logic frame_abort_out,
    output logic cmd_while_busy_out,
    output logic serial_out,
    output logic serial_oe_out
);

    epdsh_pin_if #(.WIDTH(PIN_COUNT)) pin_bus ();

    assign pin_bus.raw[PIN_SCLK] = sclk_in;
    assign pin_bus.raw[PIN_SERIAL_IN_LINE] = serial_in_line_in;
    assign pin_bus.raw[PIN_SEL_N] = port_select_n_in;
    assign pin_bus.raw[PIN_DC] = dc_select_in;
    assign pin_bus.raw[PIN_STRAP] = iface_format_strap_in;
    assign pin_bus.raw[PIN_RST_N] = reset_in_n_in;

    // every pin, the shift clock included, arrives two flops late; the host
    // must hold its clock high and low for more than one system clock each or edges are lost
    epdsh_sync u_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .pins(pin_bus.sync_side)
    );

    // synchronised pin levels
    wire logic sclk_s;
    wire logic serial_in_line_s;
    wire logic sel_n_s;
    wire logic dc_s;
    wire logic strap_s;
    wire logic rst_n_s;

    assign sclk_s = pin_bus.synced[PIN_SCLK];
    assign serial_in_line_s = pin_bus.synced[PIN_SERIAL_IN_LINE];
    assign sel_n_s = pin_bus.synced[PIN_SEL_N];
    assign dc_s = pin_bus.synced[PIN_DC];
    assign strap_s = pin_bus.synced[PIN_STRAP];
    assign rst_n_s = pin_bus.synced[PIN_RST_N];

    logic sclk_prev_r;
    logic sel_n_prev_r;
    epdsh_state_t state_r;
    epdsh_state_t state_nxt;
    logic fmt_3w_r;
    logic fmt_3w_nxt;
    logic [FRAME_W-1:0] shift_r;
    logic [FRAME_W-1:0] shift_nxt;
    logic [3:0] count_r;
    logic [3:0] count_nxt;
    logic [BYTE_W-1:0] byte_r;
    logic [BYTE_W-1:0] byte_nxt;
    logic ram_wr_r;
    logic ram_wr_nxt;
    logic cmd_wr_r;
    logic cmd_wr_nxt;
    logic busy_r;
    logic busy_nxt;
    logic abort_r;
    logic abort_nxt;
    logic cmd_busy_r;
    logic cmd_busy_nxt;

    // rising edge of a synchronised level against its one-cycle-late copy
    function automatic logic rose(input logic level_now, input logic level_prev);
        return level_now & ~level_prev;
    endfunction

    // one decode serves the 3-wire flag bit and the 4-wire pin level alike
    function automatic logic marks_data(input logic level);
        return level == DC_DATA;
    endfunction

    // index of the final bit of a frame in the given format
    function automatic logic [3:0] final_index(input logic three_wire);
        return three_wire ? LAST_BIT_3W : LAST_BIT_4W;
    endfunction

    // edge and frame decode
    wire logic sclk_rise;
    wire logic sel_rise;
    wire logic selected;
    wire logic pin_reset;
    wire logic take_bit;
    wire logic [3:0] last_bit;
    wire logic frame_done;
    wire logic [FRAME_W-1:0] shifted;
    wire logic route_data;
    wire logic partial;
    wire logic flag_data;
    wire logic pin_data;
    wire logic [BYTE_W-1:0] payload;
    wire logic deliver;

    // edges are found from the second flop against a third, since the sync
    // delay is equal for clock and data the sampled bit lines up with its edge
    assign sclk_rise = rose(sclk_s, sclk_prev_r);
    assign sel_rise = rose(sel_n_s, sel_n_prev_r);
    assign selected = ~sel_n_s;
    assign pin_reset = ~rst_n_s;
    assign take_bit = (state_r == ST_SHIFT) & selected & sclk_rise;
    assign last_bit = final_index(fmt_3w_r);
    assign frame_done = take_bit & (count_r == last_bit);
    assign shifted = {shift_r[FRAME_W-2:0], serial_in_line_s};
    assign partial = count_r != CNT_ZERO;
    assign payload = shifted[BYTE_W-1:0];
    assign deliver = frame_done & ~pin_reset;

    // 3-wire: the first bit of the frame has reached the top of the register;
    // 4-wire: the pin level is sampled only on the final edge of the byte.
    // in 3-wire the pin level is ignored, so a host that does not tie it low
    // does no harm
    assign flag_data = marks_data(shifted[FRAME_W-1]);
    assign pin_data = marks_data(dc_s);
    assign route_data = fmt_3w_r ? flag_data : pin_data;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            // nothing is taken while the reset pin holds the port here
            ST_HELD: begin
                if (!pin_reset) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (pin_reset) begin
                    state_nxt = ST_HELD;
                end else if (selected) begin
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (pin_reset) begin
                    state_nxt = ST_HELD;
                end else if (!selected) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_HELD;
            end
        endcase
    end

    // the strap is static; it is re-read only while the port is held or idle so a
    // slow strap change never splits a frame between two formats
    always_comb begin
        fmt_3w_nxt = fmt_3w_r;
        if (state_r != ST_SHIFT) begin
            fmt_3w_nxt = (strap_s == STRAP_3WIRE);
        end
    end

    always_comb begin
        shift_nxt = shift_r;
        count_nxt = count_r;
        if (pin_reset) begin
            shift_nxt = SHIFT_RST;
            count_nxt = CNT_ZERO;
        end else if (!selected) begin
            shift_nxt = SHIFT_RST;
            count_nxt = CNT_ZERO;
        end else if (frame_done) begin
            // restart per byte so bytes may follow back to back under one select
            shift_nxt = SHIFT_RST;
            count_nxt = CNT_ZERO;
        end else if (take_bit) begin
            shift_nxt = shifted;
            count_nxt = count_r + 4'h1;
        end
    end

    always_comb begin
        byte_nxt = byte_r;
        ram_wr_nxt = 1'b0;
        cmd_wr_nxt = 1'b0;
        cmd_busy_nxt = 1'b0;
        if (deliver) begin
            byte_nxt = payload;
            ram_wr_nxt = route_data;
            cmd_wr_nxt = ~route_data;
            // the host ought to wait for busy to fall; flag it, still deliver
            cmd_busy_nxt = ~route_data & busy_r;
        end
    end

    // a select pulse between frames finds the counter at zero and is not flagged
    assign abort_nxt = (state_r == ST_SHIFT) & sel_rise & partial;
    assign busy_nxt = waveform_active_in | otp_program_in | sensor_xfer_in;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sclk_prev_r <= 1'b0;
            sel_n_prev_r <= 1'b1;
        end else begin
            sclk_prev_r <= sclk_s;
            sel_n_prev_r <= sel_n_s;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r <= ST_HELD;
            fmt_3w_r <= STRAP_4WIRE;
            shift_r <= SHIFT_RST;
            count_r <= CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            fmt_3w_r <= fmt_3w_nxt;
            shift_r <= shift_nxt;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            byte_r <= BYTE_RST;
            ram_wr_r <= 1'b0;
            cmd_wr_r <= 1'b0;
            cmd_busy_r <= 1'b0;
        end else begin
            byte_r <= byte_nxt;
            ram_wr_r <= ram_wr_nxt;
            cmd_wr_r <= cmd_wr_nxt;
            cmd_busy_r <= cmd_busy_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            busy_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            abort_r <= abort_nxt;
        end
    end

    // the data pin is input only; these flops never leave zero
    logic sdo_r;
    logic sdo_oe_r;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end
    end

    assign byte_out = byte_r;
    assign ram_write_out = ram_wr_r;
    assign cmd_write_out = cmd_wr_r;
    assign busy_out = busy_r;
    assign format_3wire_out = fmt_3w_r;
    assign frame_abort_out = abort_r;
    assign cmd_while_busy_out = cmd_busy_r;
    assign serial_out = sdo_r;
    assign serial_oe_out = sdo_oe_r;

endmodule

`default_nettype wire

// *** test/epdsh_host_model.sv ***
`default_nettype none
module epdsh_host_model (
    input wire logic clk_in,
    output logic sclk_out,
    output logic serial_in_line_out,
    output logic sel_n_out,
    output logic dc_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk_out = 1'b0;
        serial_in_line_out = 1'b0;
        sel_n_out = 1'b1;
        dc_out = 1'b0;
    end
    // stop below n cuts the frame short; clock stands low outside frames
    task automatic send(input logic [8:0] bits, input int n, input logic dcv, input int stop,
        input logic tw);
        int i;
        repeat (2) @(posedge clk_in);
        sel_n_out <= 1'b0;
        repeat (6) @(posedge clk_in);
        for (i = n - 1; i >= n - stop; i--) begin
            serial_in_line_out <= bits[i];
            dc_out <= tw ? 1'b0 : ((i == 0) ? dcv : ~dcv);
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (6) @(posedge clk_in);
        sel_n_out <= 1'b1;
        serial_in_line_out <= ~serial_in_line_out;
    endtask
endmodule
`default_nettype wire

// *** test/epdsh_write_port_properties.sv ***
`default_nettype none
module epdsh_write_port_properties
    import epdsh_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic port_select_n_in,
    input wire logic iface_format_strap_in,
    input wire logic reset_in_n_in,
    input wire logic waveform_active_in,
    input wire logic otp_program_in,
    input wire logic sensor_xfer_in,
    input wire logic [BYTE_W-1:0] byte_out,
    input wire logic ram_write_out,
    input wire logic cmd_write_out,
    input wire logic busy_out,
    input wire logic format_3wire_out,
    input wire logic cmd_while_busy_out,
    input wire logic serial_out,
    input wire logic serial_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic act = waveform_active_in | otp_program_in | sensor_xfer_in;
    wire logic wr = ram_write_out | cmd_write_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_no_drive; !serial_oe_out && !serial_out; endproperty
    a_no_drive: assert property (p_no_drive) else $error("data line driven");
    property p_one_dest; !(ram_write_out && cmd_write_out); endproperty
    a_one_dest: assert property (p_one_dest) else $error("two targets");
    property p_busy; !$past(srst_in) |-> busy_out == $past(act); endproperty
    a_busy: assert property (p_busy) else $error("busy wrong");
    property p_cwb; cmd_while_busy_out |-> cmd_write_out; endproperty
    a_cwb: assert property (p_cwb) else $error("flag without command");
    property p_pulse; wr |=> !wr; endproperty
    a_pulse: assert property (p_pulse) else $error("write too long");
    property p_hold; !$past(srst_in) && !wr |-> $stable(byte_out); endproperty
    a_hold: assert property (p_hold) else $error("byte moved");
    property p_desel; port_select_n_in [*6] |=> !wr; endproperty
    a_desel: assert property (p_desel) else $error("write deselected");
    property p_pinrst; !reset_in_n_in [*6] |=> !wr; endproperty
    a_pinrst: assert property (p_pinrst) else $error("write in pin reset");
    property p_fmt;
        (port_select_n_in && $stable(iface_format_strap_in)) [*6]
            |=> format_3wire_out == $past(iface_format_strap_in);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format wrong");
endmodule
`default_nettype wire

// *** test/tb_epdsh_write_port.sv ***
`default_nettype none
module tb_epdsh_write_port;
    import epdsh_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic strap = 1'b0;
    logic rst_n = 1'b1;
    logic [2:0] act = 3'h0;
    wire logic sclk, serial_in_line, sel_n, dc;
    logic [BYTE_W-1:0] byte_out, got;
    logic ram_w, cmd_w, busy, fmt, abort, cwb, so, soe, gcwb;
    logic [1:0] kind;
    int error_cnt = 0;
    int checks = 0;
    int aborts = 0;
    epdsh_host_model host_i (.clk_in(clk_in), .sclk_out(sclk), .serial_in_line_out(serial_in_line),
        .sel_n_out(sel_n), .dc_out(dc));
    epdsh_write_port epdsh_write_port_i (.clk_in(clk_in), .srst_in(srst_in), .sclk_in(sclk),
        .serial_in_line_in(serial_in_line), .port_select_n_in(sel_n), .dc_select_in(dc),
        .iface_format_strap_in(strap), .reset_in_n_in(rst_n), .waveform_active_in(act[0]),
        .otp_program_in(act[1]), .sensor_xfer_in(act[2]), .byte_out(byte_out),
        .ram_write_out(ram_w), .cmd_write_out(cmd_w), .busy_out(busy),
        .format_3wire_out(fmt), .frame_abort_out(abort), .cmd_while_busy_out(cwb),
        .serial_out(so), .serial_oe_out(soe));
    initial forever #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (ram_w || cmd_w) begin
            got <= byte_out;
            kind <= {ram_w, cmd_w};
            gcwb <= cwb;
        end
        if (abort)
            aborts <= aborts + 1;
    end
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_4wire;
        host_i.send(9'h0A5, 8, 1'b1, 8, 1'b0);
        chk(got, 8'hA5);
        chk(kind, 2'h2);
        host_i.send(9'h03C, 8, 1'b0, 8, 1'b0);
        chk(got, 8'h3C);
        chk(kind, 2'h1);
        chk(fmt, STRAP_4WIRE);
    endtask
    task automatic t_3wire;
        strap <= STRAP_3WIRE;
        repeat (10) @(posedge clk_in);
        chk(fmt, STRAP_3WIRE);
        host_i.send(9'h15A, 9, 1'b0, 9, 1'b1);
        chk(got, 8'h5A);
        chk(kind, 2'h2);
        host_i.send(9'h0C3, 9, 1'b0, 9, 1'b1);
        chk(got, 8'hC3);
        chk(kind, 2'h1);
        strap <= STRAP_4WIRE;
        repeat (10) @(posedge clk_in);
    endtask
    task automatic t_abort;
        int a0;
        a0 = aborts;
        host_i.send(9'h0FF, 8, 1'b1, 4, 1'b0);
        repeat (6) @(posedge clk_in);
        chk(aborts - a0, 9'h001);
        chk(got, 8'hC3);
        host_i.send(9'h066, 8, 1'b1, 8, 1'b0);
        chk(got, 8'h66);
    endtask
    task automatic t_resetpin;
        fork
            host_i.send(9'h099, 8, 1'b1, 8, 1'b0);
            begin
                repeat (30) @(posedge clk_in);
                rst_n <= 1'b0;
                repeat (10) @(posedge clk_in);
                rst_n <= 1'b1;
            end
        join
        chk(got, 8'h66);
        host_i.send(9'h042, 8, 1'b1, 8, 1'b0);
        chk(got, 8'h42);
    endtask
    task automatic t_busy;
        int i;
        for (i = 0; i < 3; i++) begin
            act <= 3'h1 << i;
            repeat (2) @(negedge clk_in);
            chk(busy, 1'b1);
            @(posedge clk_in);
            act <= 3'h0;
            @(posedge clk_in);
        end
        act <= 3'h1;
        host_i.send(9'h012, 8, 1'b0, 8, 1'b0);
        chk(got, 8'h12);
        chk(gcwb, 1'b1);
        act <= 3'h0;
        repeat (3) @(negedge clk_in);
        chk(busy, 1'b0);
        chk({so, soe}, 2'h0);
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        t_4wire();
        t_3wire();
        t_abort();
        t_resetpin();
        t_busy();
        end_of_test();
    end
    initial begin
        #1000000;
        error_cnt++;
        end_of_test();
    end
endmodule
bind epdsh_write_port epdsh_write_port_properties props_i (.clk_in(clk_in),
    .srst_in(srst_in), .port_select_n_in(port_select_n_in),
    .iface_format_strap_in(iface_format_strap_in), .reset_in_n_in(reset_in_n_in),
    .waveform_active_in(waveform_active_in), .otp_program_in(otp_program_in),
    .sensor_xfer_in(sensor_xfer_in), .byte_out(byte_out), .ram_write_out(ram_write_out),
    .cmd_write_out(cmd_write_out), .busy_out(busy_out), .format_3wire_out(format_3wire_out),
    .cmd_while_busy_out(cmd_while_busy_out), .serial_out(serial_out),
    .serial_oe_out(serial_oe_out));
`default_nettype wire
